//--- core/prog_entry_pkg.sv
`default_nettype none
package prog_entry_pkg;

  localparam int          CLK_HZ            = 10_000_000;
  localparam int          BAUD_BPS          = 9600;
  localparam int          BIT_CYCLES        = CLK_HZ / BAUD_BPS;
  localparam int          HALF_BIT_CYCLES   = BIT_CYCLES / 2;
  localparam int          DATA_BITS         = 8;
  localparam int          PORT_WIDTH        = 8;
  localparam logic [7:0]  MATCH_BYTE        = 8'h5A;
  localparam logic        PORT_ENABLE_RESET = 1'b0;
  localparam logic        PORT_FIXED_LEVEL  = 1'b0;

  typedef enum {
    ST_STRAP,
    ST_USER,
    ST_PROG
  } mode_state_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rx_byte_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } tx_byte_t;

endpackage
`default_nettype wire

//--- core/uart_8n1.sv
`timescale 1ns/10ps
`default_nettype none
module uart_8n1
  import prog_entry_pkg::*;
(
  input  wire logic     i_clk_sys,
  input  wire logic     i_reset,
  input  wire logic     i_enable,
  input  wire logic     i_rx_sync,
  input  wire tx_byte_t i_tx,
  output logic          o_tx_ready,
  output logic          o_tx_line,
  output rx_byte_t      o_rx
);

  localparam logic [15:0] BIT_CNT  = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF_CNT = 16'(HALF_BIT_CYCLES - 1);

  logic [15:0] rx_timer_reg;
  logic [3:0]  rx_bit_reg;
  logic [7:0]  rx_shift_reg;
  logic        rx_busy_reg;
  logic [15:0] tx_timer_reg;
  logic [3:0]  tx_bit_reg;
  logic [9:0]  tx_shift_reg;
  logic        tx_busy_reg;

  ////////////////////////////////////////////////////////////////////////
  // Receiver, 8 data bits, no parity, 1 stop bit
  always_ff @(posedge i_clk_sys) begin
    o_rx.valid <= 1'b0;
    if (i_reset || !i_enable) begin
      rx_busy_reg  <= 1'b0;
      rx_timer_reg <= 16'h0000;
      rx_bit_reg   <= 4'h0;
      rx_shift_reg <= 8'h00;
      o_rx.data    <= 8'h00;
    end else if (!rx_busy_reg) begin
      if (!i_rx_sync) begin
        rx_busy_reg  <= 1'b1;
        rx_timer_reg <= HALF_CNT;
        rx_bit_reg   <= 4'h0;
      end
    end else if (rx_timer_reg != 16'h0000) begin
      rx_timer_reg <= rx_timer_reg - 16'h0001;
    end else begin
      rx_timer_reg <= BIT_CNT;
      rx_bit_reg   <= rx_bit_reg + 4'h1;
      if (rx_bit_reg == 4'h0) begin
        if (i_rx_sync) begin
          rx_busy_reg <= 1'b0;
        end
      end else if (rx_bit_reg <= 4'(DATA_BITS)) begin
        rx_shift_reg <= {i_rx_sync, rx_shift_reg[7:1]};
      end else begin
        rx_busy_reg <= 1'b0;
        if (i_rx_sync) begin
          o_rx.valid <= 1'b1;
          o_rx.data  <= rx_shift_reg;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmitter
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || !i_enable) begin
      tx_busy_reg  <= 1'b0;
      tx_timer_reg <= 16'h0000;
      tx_bit_reg   <= 4'h0;
      tx_shift_reg <= 10'h3FF;
      o_tx_line    <= 1'b1;
      o_tx_ready   <= 1'b0;
    end else if (!tx_busy_reg) begin
      o_tx_line  <= 1'b1;
      o_tx_ready <= 1'b1;
      if (i_tx.valid && o_tx_ready) begin
        tx_busy_reg  <= 1'b1;
        o_tx_ready   <= 1'b0;
        tx_shift_reg <= {1'b1, i_tx.data, 1'b0};
        tx_timer_reg <= BIT_CNT;
        tx_bit_reg   <= 4'h0;
      end
    end else begin
      o_tx_line <= tx_shift_reg[0];
      if (tx_timer_reg != 16'h0000) begin
        tx_timer_reg <= tx_timer_reg - 16'h0001;
      end else begin
        tx_timer_reg <= BIT_CNT;
        tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
        tx_bit_reg   <= tx_bit_reg + 4'h1;
        if (tx_bit_reg == 4'(DATA_BITS + 1)) begin
          tx_busy_reg <= 1'b0;
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- core/serial_prog_mode_entry.sv
`timescale 1ns/10ps
`default_nettype none
module serial_prog_mode_entry
  import prog_entry_pkg::*;
#(
  parameter int PORTS = PORT_WIDTH
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset,
  input  wire logic             i_test_select,
  input  wire logic             i_boot_strap_receive_pin,
  input  wire logic [PORTS-1:0] i_port_pin,
  input  wire logic [PORTS-1:0] i_port_out,
  input  wire logic [PORTS-1:0] i_port_dir_out,
  input  wire logic             i_user_tx_line,
  input  wire logic             i_port_input_enable_wr,
  input  wire logic             i_port_input_enable_data,
  input  wire tx_byte_t         i_tx,
  output logic                  o_prog_mode,
  output logic                  o_matched,
  output logic                  o_serial_transmit_out,
  output logic                  o_serial_transmit_oe,
  output logic [PORTS-1:0]      o_port_out,
  output logic [PORTS-1:0]      o_port_oe,
  output logic [PORTS-1:0]      o_port_in,
  output logic                  o_port_input_enable_reg,
  output logic                  o_tx_ready,
  output rx_byte_t              o_rx
);

  logic             test_meta_reg;
  logic             test_sync_reg;
  logic             boot_meta_reg;
  logic             boot_sync_reg;
  logic [PORTS-1:0] port_meta_reg;
  logic [PORTS-1:0] port_sync_reg;
  mode_state_t      state_reg;
  logic             in_prog;
  logic             in_user;
  logic             uart_tx_line;
  logic             uart_tx_ready;
  rx_byte_t         uart_rx;

  // Mode decode shared by the pin muxes
  function automatic logic mode_is(input mode_state_t cur, input mode_state_t want);
    return (cur == want);
  endfunction

  // Level every ignored port input is held at
  function automatic logic [PORTS-1:0] fixed_ports();
    return {PORTS{PORT_FIXED_LEVEL}};
  endfunction

  // Current mode, decoded once
  assign in_prog = mode_is(state_reg, ST_PROG);
  assign in_user = mode_is(state_reg, ST_USER);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Test-select strap
  always_ff @(posedge i_clk_sys) begin
    test_meta_reg <= i_test_select;
    test_sync_reg <= test_meta_reg;
  end

  // Boot strap, later the receive line
  always_ff @(posedge i_clk_sys) begin
    boot_meta_reg <= i_boot_strap_receive_pin;
    boot_sync_reg <= boot_meta_reg;
  end

  // General port pins
  always_ff @(posedge i_clk_sys) begin
    port_meta_reg <= i_port_pin;
    port_sync_reg <= port_meta_reg;
  end

  ////////////////////////////////////////////////////////////////////////
  // Strap capture at the first edge after reset release
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_reg <= ST_STRAP;
    end else begin
      case (state_reg)
        ST_STRAP: begin
          if (test_sync_reg && boot_sync_reg) begin
            state_reg <= ST_PROG;
          end else begin
            state_reg <= ST_USER;
          end
        end
        ST_USER: state_reg <= ST_USER;
        ST_PROG: state_reg <= ST_PROG;
        default: state_reg <= ST_STRAP;
      endcase
    end
  end

  // Mode flag to the core
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_prog_mode <= 1'b0;
    end else begin
      o_prog_mode <= in_prog;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Boot pin reused as UART receive once in programming mode
  uart_8n1 u_uart (
    .i_clk_sys  (i_clk_sys),
    .i_reset    (i_reset),
    .i_enable   (in_prog),
    .i_rx_sync  (boot_sync_reg),
    .i_tx       (i_tx),
    .o_tx_ready (uart_tx_ready),
    .o_tx_line  (uart_tx_line),
    .o_rx       (uart_rx)
  );

  // Received byte to the core
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rx <= '0;
    end else begin
      o_rx <= uart_rx;
    end
  end

  // Transmitter ready only in programming mode
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_tx_ready <= 1'b0;
    end else begin
      o_tx_ready <= uart_tx_ready && in_prog;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Matching byte seen
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_matched <= 1'b0;
    end else if (uart_rx.valid && uart_rx.data == MATCH_BYTE) begin
      o_matched <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit pin: UART in programming mode, user driver otherwise
  // Pin level
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_serial_transmit_out <= 1'b1;
    end else if (in_prog) begin
      o_serial_transmit_out <= uart_tx_line;
    end else begin
      o_serial_transmit_out <= i_user_tx_line;
    end
  end

  // Pin enable, off until the mode is decided
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_serial_transmit_oe <= 1'b0;
    end else begin
      o_serial_transmit_oe <= in_prog || in_user;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port input enable bit
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_port_input_enable_reg <= PORT_ENABLE_RESET;
    end else if (i_port_input_enable_wr) begin
      o_port_input_enable_reg <= i_port_input_enable_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // General ports
  // Output data
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || in_prog) begin
      o_port_out <= '0;
    end else begin
      o_port_out <= i_port_out;
    end
  end

  // Output enables, high impedance unless in user mode
  always_ff @(posedge i_clk_sys) begin
    if (in_user && !i_reset) begin
      o_port_oe <= i_port_dir_out;
    end else begin
      o_port_oe <= '0;
    end
  end

  // Inputs seen by the core
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_port_in <= fixed_ports();
    end else if (in_prog && !o_port_input_enable_reg) begin
      o_port_in <= fixed_ports();
    end else begin
      o_port_in <= port_sync_reg;
    end
  end

endmodule
`default_nettype wire

//--- test/prog_entry_properties.sv
`timescale 1ns/10ps
`default_nettype none
module prog_entry_properties
  import prog_entry_pkg::*;
#(
  parameter int PORTS = PORT_WIDTH
) (
  input wire logic             i_clk_sys,
  input wire logic             i_reset,
  input wire logic             i_test_select,
  input wire logic             i_boot_strap_receive_pin,
  input wire logic             i_port_input_enable_wr,
  input wire logic             i_port_input_enable_data,
  input wire logic             o_prog_mode,
  input wire logic             o_serial_transmit_out,
  input wire logic             o_serial_transmit_oe,
  input wire logic [PORTS-1:0] o_port_oe,
  input wire logic [PORTS-1:0] o_port_in,
  input wire logic             o_port_input_enable_reg,
  input wire logic             o_tx_ready,
  input wire rx_byte_t         o_rx
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////
  property p_entry;
    $rose(o_prog_mode) |-> $past(i_test_select, 4) && $past(i_boot_strap_receive_pin, 4);
  endproperty
  property p_hold; o_prog_mode && !$past(i_reset) |=> o_prog_mode; endproperty
  property p_rx; o_rx.valid |-> o_prog_mode; endproperty
  property p_tx_oe; o_prog_mode |-> o_serial_transmit_oe; endproperty
  property p_hiz; o_prog_mode |-> o_port_oe == '0; endproperty
  property p_fixed; o_prog_mode && !o_port_input_enable_reg |-> o_port_in == '0; endproperty
  property p_en_wr;
    i_port_input_enable_wr |=> o_port_input_enable_reg == $past(i_port_input_enable_data);
  endproperty
  property p_start; $fell(o_tx_ready) |=> !o_serial_transmit_out [*8]; endproperty
  a_entry: assert property (p_entry) else $error("mode entered without straps");
  a_hold: assert property (p_hold) else $error("mode lost");
  a_rx: assert property (p_rx) else $error("receive outside mode");
  a_tx_oe: assert property (p_tx_oe) else $error("transmit pin not driven");
  a_hiz: assert property (p_hiz) else $error("port driven");
  a_fixed: assert property (p_fixed) else $error("port input not fixed");
  a_en_wr: assert property (p_en_wr) else $error("enable bit not written");
  a_start: assert property (p_start) else $error("start bit short");
  c_prog: cover property ($rose(o_prog_mode));
  c_rx: cover property (o_rx.valid);
  c_en: cover property ($rose(o_port_input_enable_reg));
endmodule
bind serial_prog_mode_entry prog_entry_properties #(.PORTS(PORTS)) i_prog_entry_properties (
  .i_clk_sys, .i_reset, .i_test_select, .i_boot_strap_receive_pin, .i_port_input_enable_wr,
  .i_port_input_enable_data, .o_prog_mode, .o_serial_transmit_out, .o_serial_transmit_oe,
  .o_port_oe, .o_port_in, .o_port_input_enable_reg, .o_tx_ready, .o_rx);
`default_nettype wire

//--- test/prog_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module prog_host_model
  import prog_entry_pkg::*;
(
  input  wire logic i_clk_sys,
  input  wire logic i_tx_line,
  output logic      o_test_select,
  output logic      o_boot_line
);
  initial begin
    o_test_select = 1'b1;
    o_boot_line = 1'b1;
  end
  ////////////////////////////////////////
  task automatic set_straps(input logic t, input logic b);
    o_test_select <= t;
    o_boot_line <= b;
  endtask
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < DATA_BITS + 2; i++) begin
      @(posedge i_clk_sys);
      o_boot_line <= (i == 0) ? 1'b0 : (i > DATA_BITS) ? 1'b1 : b[i-1];
      repeat (BIT_CYCLES - 1) @(posedge i_clk_sys);
    end
  endtask
  task automatic get_byte(output logic [7:0] b);
    int n;
    n = 0;
    while (i_tx_line !== 1'b0 && n < 20000) begin
      @(negedge i_clk_sys);
      n++;
    end
    repeat (HALF_BIT_CYCLES) @(negedge i_clk_sys);
    for (int i = 0; i < DATA_BITS; i++) begin
      repeat (BIT_CYCLES) @(negedge i_clk_sys);
      b[i] = i_tx_line;
    end
  endtask
endmodule
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import prog_entry_pkg::*;
  logic       i_clk_sys, i_reset, i_test_select, i_boot_strap_receive_pin;
  logic [7:0] i_port_pin, i_port_out, i_port_dir_out, o_port_out, o_port_oe, o_port_in;
  logic       i_user_tx_line, i_port_input_enable_wr, i_port_input_enable_data;
  logic       o_prog_mode, o_matched, o_serial_transmit_out, o_serial_transmit_oe;
  logic       o_port_input_enable_reg, o_tx_ready;
  tx_byte_t   i_tx;
  rx_byte_t   o_rx;
  logic [7:0] got;
  int         err_total = 0, samples_checked = 0, cycles = 0;
  serial_prog_mode_entry i_serial_prog_mode_entry (.i_clk_sys, .i_reset, .i_test_select,
    .i_boot_strap_receive_pin, .i_port_pin, .i_port_out, .i_port_dir_out, .i_user_tx_line,
    .i_port_input_enable_wr, .i_port_input_enable_data, .i_tx, .o_prog_mode, .o_matched,
    .o_serial_transmit_out, .o_serial_transmit_oe, .o_port_out, .o_port_oe, .o_port_in,
    .o_port_input_enable_reg, .o_tx_ready, .o_rx);
  prog_host_model i_prog_host_model (.i_clk_sys, .i_tx_line(o_serial_transmit_out),
    .o_test_select(i_test_select), .o_boot_line(i_boot_strap_receive_pin));
  ////////////////////////////////////////
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_total++;
      summarize();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic do_reset();
    @(posedge i_clk_sys);
    i_reset <= 1'b1;
    repeat (8) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    repeat (4) @(negedge i_clk_sys);
  endtask
  task automatic t_entry();
    chk("prog_mode", 8'h01, o_prog_mode);
    chk("tx_oe", 8'h01, o_serial_transmit_oe);
    chk("port_oe", 8'h00, o_port_oe);
    chk("port_in", 8'h00, o_port_in);
    chk("port_out", 8'h00, o_port_out);
    chk("tx_ready", 8'h01, o_tx_ready);
    chk("matched", 8'h00, o_matched);
    $display("entry done");
  endtask
  task automatic t_match();
    int n;
    for (int k = 0; k < 2; k++) begin
      fork
        i_prog_host_model.send_byte(MATCH_BYTE);
        begin
          n = 0;
          while (o_rx.valid !== 1'b1 && n < 15000) begin
            @(negedge i_clk_sys);
            n++;
          end
          chk("rx_data", MATCH_BYTE, o_rx.data);
        end
      join
    end
    chk("matched", 8'h01, o_matched);
    $display("match done");
  endtask
  task automatic t_tx();
    int n;
    @(posedge i_clk_sys);
    i_tx <= '{1'b1, 8'hC3};
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_tx_ready !== 1'b1 && n < 100);
    i_tx <= '0;
    i_prog_host_model.get_byte(got);
    chk("tx_byte", 8'hC3, got);
    $display("transmit done");
  endtask
  task automatic t_port_en();
    @(posedge i_clk_sys);
    i_port_input_enable_wr <= 1'b1;
    i_port_input_enable_data <= 1'b1;
    @(posedge i_clk_sys);
    i_port_input_enable_wr <= 1'b0;
    repeat (2) @(negedge i_clk_sys);
    chk("enable", 8'h01, o_port_input_enable_reg);
    chk("port_in", 8'hA5, o_port_in);
    $display("port enable done");
  endtask
  task automatic t_user();
    @(posedge i_clk_sys);
    i_port_out <= 8'h3C;
    i_port_dir_out <= 8'h0F;
    i_user_tx_line <= 1'b0;
    i_prog_host_model.set_straps(1'b0, 1'b1);
    do_reset();
    chk("prog_mode", 8'h00, o_prog_mode);
    chk("matched", 8'h00, o_matched);
    chk("tx_oe", 8'h01, o_serial_transmit_oe);
    chk("tx_out", 8'h00, o_serial_transmit_out);
    chk("port_out", 8'h3C, o_port_out);
    chk("port_oe", 8'h0F, o_port_oe);
    chk("port_in", 8'hA5, o_port_in);
    @(posedge i_clk_sys);
    i_prog_host_model.set_straps(1'b1, 1'b1);
    do_reset();
    $display("user mode done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    i_reset = 1'b1;
    i_port_pin = 8'hA5;
    i_port_out = 8'hFF;
    i_port_dir_out = 8'hFF;
    i_user_tx_line = 1'b1;
    i_port_input_enable_wr = 1'b0;
    i_port_input_enable_data = 1'b0;
    i_tx = '0;
    do_reset();
    t_entry();
    t_match();
    t_tx();
    t_port_en();
    t_user();
    t_entry();
    summarize();
  end
endmodule
`default_nettype wire
